// ---- pwmt_consts.vh ----
`ifndef PWMT_CONSTS_VH
`define PWMT_CONSTS_VH
// register byte offsets
`define PWMT_OFS_START      12'h000
`define PWMT_OFS_CTRL       12'h004
`define PWMT_OFS_COUNT      12'h008
`define PWMT_OFS_STATUS     12'h00c
`define PWMT_OFS_IRQ_EN     12'h010
`define PWMT_OFS_IRQ_CTRL   12'h014
`define PWMT_OFS_PERIOD     12'h018
`define PWMT_OFS_A_ACT      12'h01c
`define PWMT_OFS_B_INACT    12'h020
`define PWMT_OFS_B_ACT      12'h024
`define PWMT_OFS_PERIOD_BUF 12'h028
`define PWMT_OFS_A_BUF      12'h02c
`define PWMT_OFS_B_INACT_BUF 12'h030
`define PWMT_OFS_B_ACT_BUF  12'h034
// start register fields
`define PWMT_RUN_BIT        0
`define PWMT_STOP_SEL_BIT   1
// counter control fields
`define PWMT_CSRC_LSB       0
`define PWMT_CLR_LSB        4
`define PWMT_BUF_EN_BIT     8
`define PWMT_ACT_A_BIT      9
`define PWMT_ACT_B_BIT      10
// irq control fields
`define PWMT_IRQ_LVL_LSB    0
`define PWMT_IRQ_REQ_BIT    3
// status flag positions
`define PWMT_ST_MATCH_A     0
`define PWMT_ST_MATCH_B     1
`define PWMT_ST_MATCH_C     2
`define PWMT_ST_MATCH_D     3
`define PWMT_ST_OVF         4
`define PWMT_ST_UDF         5
`define PWMT_NUM_SRC        6
// count source selections
`define PWMT_CS_DIV1        3'h0
`define PWMT_CS_DIV2        3'h1
`define PWMT_CS_DIV4        3'h2
`define PWMT_CS_DIV8        3'h3
`define PWMT_CS_DIV32       3'h4
`define PWMT_CS_EXT         3'h5
`define PWMT_CS_FAST_OSC    3'h6
// clear source selections
`define PWMT_CLR_PERIOD     3'h1
`define PWMT_CLR_B          3'h2
`define PWMT_CLR_SYNC       3'h3
`define PWMT_CLR_C          3'h5
`define PWMT_CLR_D          3'h6
// reset values
`define PWMT_GEN_RESET      16'hffff
`define PWMT_CTRL_RESET     11'h000
`endif

// ---- pwmt_irq.v ----
`timescale 1ns/1ps
`default_nettype none
module pwmt_irq (
	input  wire       pclk,        // bus clock
	input  wire       presetn,     // async reset, low
	input  wire       ce,          // clock enable
	input  wire [5:0] flags,       // timer_status_flags
	input  wire [5:0] enables,     // timer_irq_enable_bits
	output reg        irq_request  // irq_request_flag
);
	// level follows flags; not latched, so a cleared flag withdraws it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else if (ce) begin
			irq_request <= |(flags & enables); // R1 R2 R3 R4
		end
	end
endmodule
`default_nettype wire

// ---- pwmt_tick.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_consts.vh"
module pwmt_tick (
	input  wire       pclk,           // base_clock
	input  wire       presetn,        // async reset, low
	input  wire       ce,             // clock enable
	input  wire [2:0] sel,            // count_source_select
	input  wire       ext_clk_in,     // external count pin
	input  wire       fast_osc_clock, // fast on-chip oscillator
	output reg        tick            // one-cycle count pulse
);
	reg [4:0] div_reg;
	reg [1:0] ext_sync_reg;
	reg [1:0] osc_sync_reg;
	reg       ext_prev_reg;
	reg       osc_prev_reg;
	reg       tick_next;
	// two-stage synchronisers; only the second stage is looked at
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_reg <= 2'h0;
			osc_sync_reg <= 2'h0;
			ext_prev_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			div_reg      <= 5'h00;
		end else if (ce) begin
			ext_sync_reg <= {ext_sync_reg[0], ext_clk_in};
			osc_sync_reg <= {osc_sync_reg[0], fast_osc_clock};
			ext_prev_reg <= ext_sync_reg[1];
			osc_prev_reg <= osc_sync_reg[1];
			div_reg      <= div_reg + 5'h01;
		end
	end
	// fast osc is edge-sampled, so it must run below half of pclk
	always @* begin
		case (sel)
			`PWMT_CS_DIV1:     tick_next = 1'b1;
			`PWMT_CS_DIV2:     tick_next = (div_reg[0] == 1'b1);
			`PWMT_CS_DIV4:     tick_next = (div_reg[1:0] == 2'h3);
			`PWMT_CS_DIV8:     tick_next = (div_reg[2:0] == 3'h7);
			`PWMT_CS_DIV32:    tick_next = (div_reg == 5'h1f);
			`PWMT_CS_EXT:      tick_next = ext_sync_reg[1] & ~ext_prev_reg;
			`PWMT_CS_FAST_OSC: tick_next = osc_sync_reg[1] & ~osc_prev_reg; // R17
			default:           tick_next = 1'b0;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else if (ce) begin
			tick <= tick_next;
		end
	end
endmodule
`default_nettype wire

// ---- pwmt_top.v ----
// Behaviour
// R1 - six status sources per channel merge into one request, level and vector; code gives request and level only, no vector
// R2 - request is set while any status flag and its enable are both 1
// R3 - request drops when no flag/enable pair is set; nothing is latched
// R4 - request stays 1 while another enabled source still holds
// R5 - software finds the cause by reading the status flags
// R6 - flags never self-clear; software writes 0 to clear each one
// R7 - with stop select 0, writing run 0 is ignored
// R8 - with stop select 0, software writes run 0 when changing other bits
// R9 - stop needs stop select set first; setting both at once does not stop
// R10 - stop select 1: run 0 stops counter, outputs hold their level
// R11 - stop select 0: counter stops after the period clear, outputs hold
// R12 - counter clear beats a simultaneous software counter write
// R13 - clear source field decodes 001,010,011,101,110
// R14 - software waits briefly between writing and reading back
// R15 - software changes count source only while stopped
// R16 - software waits two base clocks before stopping the fast osc
// R17 - count source 110 selects the fast oscillator clock
// R18 - software updates period and points through buffer registers only
// R19 - counter clears on period match, period is value plus one
// R20 - outputs go active at their active-point match
// R21 - A width is period minus point, B width is inactive minus active
// R22 - buffering on: period match copies four buffers into four registers
// R23 - compare matches and overflow raise status flags
// R24 - counter increments per tick while running; outputs drop at inactive match
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_consts.vh"
module pwmt_top (
	input  wire        pclk,           // apb clock, base clock
	input  wire        presetn,        // async reset, low
	input  wire        ce,             // clock enable
	input  wire        psel,           // apb select
	input  wire        penable,        // apb enable
	input  wire        pwrite,         // apb direction
	input  wire [11:0] paddr,          // apb byte address
	input  wire [31:0] pwdata,         // apb write data
	output reg  [31:0] prdata,         // apb read data
	output reg         pready,         // apb ready
	output reg         pslverr,        // apb error, unmapped address
	input  wire        ext_clk_in,     // external count source pin
	input  wire        fast_osc_clock, // fast oscillator clock
	input  wire        sync_clear_in,  // synchronous clear from peer channel
	output reg         pwm_out_a,      // pwm output a
	output reg         pwm_out_b,      // pwm output b
	output reg         irq_request,    // irq request flag
	output reg  [2:0]  irq_level       // irq priority level
);
	reg        run_reg;
	reg        stop_sel_reg;
	reg [10:0] ctrl_reg;
	reg [15:0] count_reg;
	reg [5:0]  flags_reg;
	reg [5:0]  irq_en_reg;
	reg [2:0]  irq_lvl_reg;
	reg [15:0] period_reg;
	reg [15:0] a_act_reg;
	reg [15:0] b_inact_reg;
	reg [15:0] b_act_reg;
	reg [15:0] period_buf_reg;
	reg [15:0] a_buf_reg;
	reg [15:0] b_inact_buf_reg;
	reg [15:0] b_act_buf_reg;
	reg        a_on_reg;
	reg        b_on_reg;
	reg [1:0]  sclr_sync_reg;
	reg        run_next;
	reg [15:0] count_next;
	reg [31:0] rd_next;
	reg        hit;
	reg        clr_hit;
	wire       tick;
	wire       irq_w;
	wire       wr_done;
	wire [2:0] clr_sel;
	wire       match_a;
	wire       match_b;
	wire       match_c;
	wire       match_d;
	wire       match_aa;
	wire       match_ba;
	wire       step;
	wire [5:0] flag_set;

	// count source pulse
	pwmt_tick u_tick (
		.pclk           (pclk),
		.presetn        (presetn),
		.ce             (ce),
		.sel            (ctrl_reg[`PWMT_CSRC_LSB +: 3]),
		.ext_clk_in     (ext_clk_in),
		.fast_osc_clock (fast_osc_clock),
		.tick           (tick)
	);

	// channel interrupt aggregation
	pwmt_irq u_irq (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.flags       (flags_reg),
		.enables     (irq_en_reg),
		.irq_request (irq_w)
	);

	// one wait state: pready rises in the second access cycle
	assign wr_done = psel & penable & pready & pwrite;
	assign clr_sel = ctrl_reg[`PWMT_CLR_LSB +: 3];
	assign step    = run_reg & tick; // R24

	// compare points, checked only on a count step
	assign match_a  = step & (count_reg == period_reg);
	assign match_b  = step & (count_reg == b_inact_reg);
	assign match_c  = step & (count_reg == period_buf_reg);
	assign match_d  = step & (count_reg == b_inact_buf_reg);
	assign match_aa = step & (count_reg == a_act_reg);
	assign match_ba = step & (count_reg == b_act_reg);

	// hardware flag events; bit 5 has no source in this mode
	assign flag_set = {1'b0, step & (count_reg == 16'hffff),
		match_d, match_c, match_b, match_a}; // R23

	// peer clear arrives from outside, so it is synchronised
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclr_sync_reg <= 2'h0;
		end else if (ce) begin
			sclr_sync_reg <= {sclr_sync_reg[0], sync_clear_in};
		end
	end

	// clear source decode
	always @* begin
		case (clr_sel)
			`PWMT_CLR_PERIOD: clr_hit = match_a; // R13 R19
			`PWMT_CLR_B:      clr_hit = match_b; // R13
			`PWMT_CLR_SYNC:   clr_hit = run_reg & sclr_sync_reg[1]; // R13
			`PWMT_CLR_C:      clr_hit = match_c; // R13
			`PWMT_CLR_D:      clr_hit = match_d; // R13
			default:          clr_hit = 1'b0;
		endcase
	end

	// counter next value; a clear always beats a bus write
	always @* begin
		count_next = count_reg;
		if (step) begin
			count_next = count_reg + 16'h0001; // R24
		end
		if (wr_done && paddr == `PWMT_OFS_COUNT) begin
			count_next = pwdata[15:0];
		end
		if (clr_hit) begin
			count_next = 16'h0000; // R12
		end
		// auto-stop always lands on zero, whatever the clear source
		if (!stop_sel_reg && match_a) begin
			count_next = 16'h0000; // R11
		end
	end

	// run bit: a zero write only counts if stop select was already 1
	always @* begin
		run_next = run_reg;
		if (wr_done && paddr == `PWMT_OFS_START) begin
			if (pwdata[`PWMT_RUN_BIT]) begin
				run_next = 1'b1;
			end else if (stop_sel_reg) begin
				run_next = 1'b0; // R9 R10
			end
			// old stop select 0: zero write ignored
		end
		if (!stop_sel_reg && match_a) begin
			run_next = 1'b0; // R7 R11
		end
	end

	// counter, start and run state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg    <= 16'h0000;
			run_reg      <= 1'b0;
			stop_sel_reg <= 1'b0;
		end else if (ce) begin
			count_reg <= count_next;
			run_reg   <= run_next;
			if (wr_done && paddr == `PWMT_OFS_START) begin
				stop_sel_reg <= pwdata[`PWMT_STOP_SEL_BIT];
			end
		end
	end

	// flags: hardware set wins over a software zero in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= 6'h00;
		end else if (ce) begin
			if (wr_done && paddr == `PWMT_OFS_STATUS) begin
				flags_reg <= (flags_reg & pwdata[5:0]) | flag_set; // R6
			end else begin
				flags_reg <= flags_reg | flag_set; // R6 R23
			end
		end
	end

	// control, enables and general registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg        <= `PWMT_CTRL_RESET;
			irq_en_reg      <= 6'h00;
			irq_lvl_reg     <= 3'h0;
			period_reg      <= `PWMT_GEN_RESET;
			a_act_reg       <= `PWMT_GEN_RESET;
			b_inact_reg     <= `PWMT_GEN_RESET;
			b_act_reg       <= `PWMT_GEN_RESET;
			period_buf_reg  <= `PWMT_GEN_RESET;
			a_buf_reg       <= `PWMT_GEN_RESET;
			b_inact_buf_reg <= `PWMT_GEN_RESET;
			b_act_buf_reg   <= `PWMT_GEN_RESET;
		end else if (ce) begin
			if (wr_done) begin
				case (paddr)
					`PWMT_OFS_CTRL:        ctrl_reg        <= pwdata[10:0];
					`PWMT_OFS_IRQ_EN:      irq_en_reg      <= pwdata[5:0];
					`PWMT_OFS_IRQ_CTRL:    irq_lvl_reg     <= pwdata[2:0];
					`PWMT_OFS_PERIOD:      period_reg      <= pwdata[15:0];
					`PWMT_OFS_A_ACT:       a_act_reg       <= pwdata[15:0];
					`PWMT_OFS_B_INACT:     b_inact_reg     <= pwdata[15:0];
					`PWMT_OFS_B_ACT:       b_act_reg       <= pwdata[15:0];
					`PWMT_OFS_PERIOD_BUF:  period_buf_reg  <= pwdata[15:0];
					`PWMT_OFS_A_BUF:       a_buf_reg       <= pwdata[15:0];
					`PWMT_OFS_B_INACT_BUF: b_inact_buf_reg <= pwdata[15:0];
					`PWMT_OFS_B_ACT_BUF:   b_act_buf_reg   <= pwdata[15:0];
					default: ;
				endcase
			end
			// buffer transfer at the period boundary overrides a direct write
			if (match_a && ctrl_reg[`PWMT_BUF_EN_BIT]) begin
				period_reg  <= period_buf_reg; // R22
				a_act_reg   <= a_buf_reg;
				b_inact_reg <= b_inact_buf_reg;
				b_act_reg   <= b_act_buf_reg;
			end
		end
	end

	// waveform state; frozen while stopped, so levels hold
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_on_reg <= 1'b0;
			b_on_reg <= 1'b0;
		end else if (ce) begin
			if (match_a) begin
				a_on_reg <= 1'b0; // R21 R24 R11
			end else if (match_aa) begin
				a_on_reg <= 1'b1; // R20
			end
			if (match_b) begin
				b_on_reg <= 1'b0; // R21 R24
			end else if (match_ba) begin
				b_on_reg <= 1'b1; // R20
			end
		end
	end

	// pins: active level per output, inactive is its inverse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
		end else if (ce) begin
			pwm_out_a <= ~(a_on_reg ^ ctrl_reg[`PWMT_ACT_A_BIT]); // R10
			pwm_out_b <= ~(b_on_reg ^ ctrl_reg[`PWMT_ACT_B_BIT]); // R10
		end
	end

	// irq pins; request lags its sources by two cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
			irq_level   <= 3'h0;
		end else if (ce) begin
			irq_request <= irq_w; // R1
			irq_level   <= irq_lvl_reg; // R1
		end
	end

	// read mux
	always @* begin
		rd_next = 32'h0000_0000;
		case (paddr)
			`PWMT_OFS_START:       rd_next = {30'h0, stop_sel_reg, run_reg};
			`PWMT_OFS_CTRL:        rd_next = {21'h0, ctrl_reg};
			`PWMT_OFS_COUNT:       rd_next = {16'h0, count_reg};
			`PWMT_OFS_STATUS:      rd_next = {26'h0, flags_reg}; // R5
			`PWMT_OFS_IRQ_EN:      rd_next = {26'h0, irq_en_reg};
			`PWMT_OFS_IRQ_CTRL:    rd_next = {28'h0, irq_w, irq_lvl_reg};
			`PWMT_OFS_PERIOD:      rd_next = {16'h0, period_reg};
			`PWMT_OFS_A_ACT:       rd_next = {16'h0, a_act_reg};
			`PWMT_OFS_B_INACT:     rd_next = {16'h0, b_inact_reg};
			`PWMT_OFS_B_ACT:       rd_next = {16'h0, b_act_reg};
			`PWMT_OFS_PERIOD_BUF:  rd_next = {16'h0, period_buf_reg};
			`PWMT_OFS_A_BUF:       rd_next = {16'h0, a_buf_reg};
			`PWMT_OFS_B_INACT_BUF: rd_next = {16'h0, b_inact_buf_reg};
			`PWMT_OFS_B_ACT_BUF:   rd_next = {16'h0, b_act_buf_reg};
			default:               rd_next = 32'h0000_0000;
		endcase
	end

	// only listed offsets answer, so a gap in the map is refused too
	always @* begin
		case (paddr)
			`PWMT_OFS_START,
			`PWMT_OFS_CTRL,
			`PWMT_OFS_COUNT,
			`PWMT_OFS_STATUS,
			`PWMT_OFS_IRQ_EN,
			`PWMT_OFS_IRQ_CTRL,
			`PWMT_OFS_PERIOD,
			`PWMT_OFS_A_ACT,
			`PWMT_OFS_B_INACT,
			`PWMT_OFS_B_ACT,
			`PWMT_OFS_PERIOD_BUF,
			`PWMT_OFS_A_BUF,
			`PWMT_OFS_B_INACT_BUF,
			`PWMT_OFS_B_ACT_BUF: hit = 1'b1;
			default:             hit = 1'b0;
		endcase
	end

	// apb slave: one wait cycle, data and error registered with pready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_next;
			end
		end
	end
endmodule
`default_nettype wire

// ---- pwmt_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwmt_props (
	input wire logic        pclk,        // clock
	input wire logic        presetn,     // reset, low
	input wire logic        ce,          // clock enable
	input wire logic        psel,        // apb select
	input wire logic        penable,     // apb enable
	input wire logic        pwrite,      // apb direction
	input wire logic [11:0] paddr,       // apb address
	input wire logic [31:0] pwdata,      // apb write data
	input wire logic [31:0] prdata,      // apb read data
	input wire logic        pready,      // apb ready
	input wire logic        pslverr,     // apb error
	input wire logic        pwm_out_a,   // output a
	input wire logic        pwm_out_b,   // output b
	input wire logic        irq_request, // request
	input wire logic [2:0]  irq_level    // level
);
	// completed transfers
	wire done = psel && penable && pready;
	wire lvl_wr = done && pwrite && paddr == 12'h014;
	logic [2:0] lvl_exp;

	// level last written, for the copy check
	always_ff @(posedge pclk)
		if (lvl_wr)
			lvl_exp <= pwdata[2:0];

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_one: assert property (psel && penable && !pready && ce |=> pready)
		else $error("no ready one cycle after access");
	chk_ready_pulse: assert property (pready && ce |=> !pready)
		else $error("ready held longer than one cycle");
	chk_err_pair: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_unmapped: assert property (done && paddr > 12'h034 |-> pslverr)
		else $error("unmapped address not refused");
	chk_err_mapped: assert property (done && paddr <= 12'h034 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped address refused");
	chk_err_rdzero: assert property (done && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	chk_level_copy: assert property (lvl_wr |=> ##[0:1] irq_level == lvl_exp)
		else $error("level field not copied");
	chk_level_cause: assert property ($changed(irq_level) |-> $past(lvl_wr) || $past(lvl_wr, 2))
		else $error("level changed without a write");
	chk_freeze_ce: assert property (!ce |=> $stable({pwm_out_a, pwm_out_b, irq_request, pready}))
		else $error("outputs moved with enable low");
endmodule
bind pwmt_top pwmt_props i_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
	.irq_request(irq_request), .irq_level(irq_level));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] all_m = 32'hffffffff;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic        ext_clk_in = 0, fast_osc_clock = 0, sync_clear_in = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [1:0]  hold;
	wire  [31:0] prdata;
	wire  [2:0]  irq_level;
	wire         pready, pslverr, pwm_out_a, pwm_out_b, irq_request;
	logic [32:0] exp_q[$], msk_q[$];
	int          err_count = 0, n_compared = 0, cyc = 0;
	int          P, n, p, q, hi, per, lim[4];
	int          cd[4] = '{1, 2, 5, 6};
	int          sr[4] = '{1, 2, 5, 6};
	int          mu[4] = '{2, 4, 4, 3};

	// clocks; both count sources stay below half the bus rate
	always #10 pclk = ~pclk;
	always #30 fast_osc_clock = ~fast_osc_clock;
	always #40 ext_clk_in = ~ext_clk_in;

	pwmt_top i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_clk_in, .fast_osc_clock, .sync_clear_in,
		.pwm_out_a, .pwm_out_b, .irq_request, .irq_level);

	task chk(input logic [32:0] g, input logic [32:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %0h want %0h", $time, g, e);
		end
	endtask

	task stop_test;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task done_t(input string s);
		$display("test %s done", s);
	endtask

	// one apb transfer; bb keeps select up for a chained setup
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit bb);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!bb) begin
			psel <= 0;
			penable <= 0;
			@(posedge pclk);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 0);
	endtask

	// note the expected word first, the monitor compares it
	task rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back({1'b1, m});
		apb(0, a, 0, 0);
	endtask

	task irq_is(input logic e);
		repeat (4) @(posedge pclk);
		chk(irq_request, e);
	endtask

	function automatic logic [31:0] cr(input int s, input int c, input int bf);
		return 32'h600 | (bf << 8) | (c << 4) | s;
	endfunction

	// one rising edge to the next: high samples and period
	task meas(input bit b);
		logic s, l;
		s = 1'b1;
		hi = 0;
		per = 0;
		do begin
			l = s;
			@(posedge pclk);
			s = b ? pwm_out_b : pwm_out_a;
		end while (!(l === 1'b0 && s === 1'b1));
		do begin
			hi += (s === 1'b1);
			per++;
			l = s;
			@(posedge pclk);
			s = b ? pwm_out_b : pwm_out_a;
		end while (!(l === 1'b0 && s === 1'b1));
	endtask

	// read monitor, oldest note first
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
		end

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			$display("[FAIL] %0t timeout", $time);
			stop_test;
		end
	end

	initial begin
		void'($urandom(46));
		P = 24 + $urandom % 16;
		n = 4 + $urandom % 16;
		q = 2 + $urandom % 4;
		p = q + 3 + $urandom % 8;
		lim = '{P, p, p + 3, p + 5};
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int a = 0; a <= 'h34; a += 4)
			rd(a, a < 'h18 ? 0 : 'hffff, all_m);
		rd('h40, 33'h100000000, all_m);
		wr('h40, 32'h5a);
		done_t("reset");
		wr('h018, P);
		wr('h01c, n);
		wr('h020, p);
		wr('h024, q);
		wr('h004, cr(0, 1, 0));
		wr('h000, 3);
		meas(0);
		chk(per, P + 1);
		chk(hi, P - n);
		meas(1);
		chk(hi, p - q);
		chk(per, P + 1);
		ce <= 0;
		repeat (6) @(posedge pclk);
		ce <= 1;
		wr(0, 2);
		@(posedge pclk);
		hold = {pwm_out_a, pwm_out_b};
		repeat (3 * P) @(posedge pclk);
		chk({pwm_out_a, pwm_out_b}, hold);
		rd(0, 2, all_m);
		done_t("pwm");
		rd('h00c, 3, 3);
		wr('h014, 5);
		rd('h014, 5, 7);
		chk(irq_level, 5);
		wr('h010, 3);
		irq_is(1);
		wr('h00c, 'h3e);
		irq_is(1);
		rd('h00c, 2, 3);
		wr('h00c, 'h3d);
		irq_is(0);
		wr(8, 'hffff);
		wr(0, 3);
		wr(0, 2);
		rd('h00c, 'h10, 'h10);
		wr('h010, 'h10);
		irq_is(1);
		wr('h010, 0);
		irq_is(0);
		done_t("irq");
		wr(8, 0);
		wr(0, 1);
		wr(0, 0);
		rd(0, 1, 3);
		repeat (3 * P) @(posedge pclk);
		rd(0, 0, 3);
		rd(8, 0, all_m);
		chk(pwm_out_a, 0);
		wr(0, 1);
		wr(0, 2);
		rd(0, 3, 3);
		wr(0, 2);
		rd(0, 2, 3);
		// chained writes land the second counter write on the clear edge
		wr(8, 0);
		apb(1, 0, 1, 1);
		apb(1, 8, P - 2, 1);
		apb(1, 8, 'h1234, 0);
		rd(8, 0, all_m);
		done_t("stop");
		wr('h028, p + 3);
		wr('h030, p + 5);
		wr(0, 2);
		for (int i = 0; i < 4; i++) begin
			wr(4, cr(0, cd[i], 0));
			wr(8, 0);
			wr(0, 3);
			meas(1);
			chk(per, lim[i] + 1);
			wr(0, 2);
		end
		wr(4, cr(0, 3, 0));
		wr(8, 0);
		wr(0, 3);
		sync_clear_in <= 1;
		repeat (8) @(posedge pclk);
		rd(8, 0, all_m);
		sync_clear_in <= 0;
		wr(0, 2);
		// sync jitter allows two cycles either way
		for (int i = 0; i < 4; i++) begin
			wr(4, cr(sr[i], 1, 0));
			wr(8, 0);
			wr(0, 3);
			meas(0);
			chk(per > mu[i] * (P + 1) - 3 && per < mu[i] * (P + 1) + 3, 1);
			wr(0, 2);
		end
		done_t("sources");
		wr('h028, P + 4);
		wr('h02c, n + 1);
		wr('h030, p + 1);
		wr('h034, q + 2);
		wr(4, cr(0, 1, 1));
		repeat (2) @(posedge pclk);
		wr(8, 0);
		wr(0, 3);
		meas(0);
		meas(0);
		chk(per, P + 5);
		chk(hi, P + 3 - n);
		meas(1);
		chk(hi, p - q - 1);
		wr(0, 2);
		rd('h018, P + 4, all_m);
		done_t("buffer");
		stop_test;
	end
endmodule
`default_nettype wire
